// ---- pkg/otpb_pkg.sv ----
package otpb_pkg;
    // Command codes on the command port
    localparam logic [15:0] CMD_OTP_ACCESS = 16'h0065;
    localparam logic [15:0] CMD_LOAD       = 16'h0000;
    localparam logic [15:0] CMD_LOAD_SPARE = 16'h0013;
    localparam logic [15:0] CMD_LOAD_ALT   = 16'h00E0;
    localparam logic [15:0] CMD_PROGRAM    = 16'h0080;
    localparam logic [15:0] CMD_ERASE      = 16'h0094;
    localparam logic [15:0] CMD_CORE_RESET = 16'h00F0;
    localparam logic [15:0] CMD_HOT_RESET  = 16'h00F3;
    // Address register selects on the link
    localparam logic [1:0]  AR_BLOCK  = 2'h0;
    localparam logic [1:0]  AR_PAGE   = 2'h1;
    localparam logic [1:0]  AR_SECTOR = 2'h2;
    localparam logic [1:0]  AR_BUFSEL = 2'h3;
    // Buffer selects
    localparam logic [1:0]  BUF_BOOT  = 2'h0;
    localparam logic [1:0]  BUF_DATA0 = 2'h1;
    localparam logic [1:0]  BUF_DATA1 = 2'h2;
    // Block geometry
    localparam int          OTP_PAGES      = 64;
    localparam logic [5:0]  OTP_USER_LAST  = 6'h09;
    localparam logic [3:0]  LOCK_NIBBLE    = 4'hC;
    localparam int          BUF_WORDS      = 16;
    localparam logic [3:0]  LOCK_WORD_IDX  = 4'h7;
    // Controller status bits
    localparam int          ST_ERROR  = 10;
    localparam int          ST_LOCKED = 6;
    localparam int          ST_BUSY   = 15;
    localparam int          ST_OTPMOD = 0;
    // Timing
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          TOGGLE_VALID_NS = 350;
    localparam int          TOGGLE_CYC      =
        (TOGGLE_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          LOAD_CYC        = 64;
    localparam int          PROG_CYC        = 96;
    localparam int          BOOT_CYC        = 48;
    // Host APB register map
    localparam logic [11:0] RG_CMD    = 12'h000;
    localparam logic [11:0] RG_ADDR   = 12'h004;
    localparam logic [11:0] RG_WDATA  = 12'h008;
    localparam logic [11:0] RG_RDATA  = 12'h00C;
    localparam logic [11:0] RG_STATUS = 12'h010;
    localparam logic [11:0] RG_OP     = 12'h014;
    // Host operation kinds in RG_OP
    localparam logic [1:0]  OP_CMD    = 2'h0;
    localparam logic [1:0]  OP_ADDR   = 2'h1;
    localparam logic [1:0]  OP_WRITE  = 2'h2;
    localparam logic [1:0]  OP_READ   = 2'h3;
    localparam logic [31:0] APB_ERRV  = 32'hDEAD_0000;
endpackage : otpb_pkg

// ---- pkg/otpb_link_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface otpb_link_if;
    logic        cmdValid;
    logic [15:0] cmdCode;
    logic        addrValid;
    logic [1:0]  addrSel;
    logic [15:0] addrData;
    logic        wrValid;
    logic [3:0]  wrIdx;
    logic [15:0] wrData;
    logic        rdValid;
    logic [3:0]  rdIdx;
    logic        rdDone;
    logic [15:0] rdData;
    logic [15:0] ctrlStatus;
    logic        coldRst;
    logic        warmRst;

    modport dev (
        input  cmdValid, cmdCode, addrValid, addrSel, addrData,
        input  wrValid, wrIdx, wrData, rdValid, rdIdx, coldRst, warmRst,
        output rdDone, rdData, ctrlStatus
    );
    modport hst (
        output cmdValid, cmdCode, addrValid, addrSel, addrData,
        output wrValid, wrIdx, wrData, rdValid, rdIdx, coldRst, warmRst,
        input  rdDone, rdData, ctrlStatus
    );
endinterface : otpb_link_if
`default_nettype wire

// ---- rtl/otpb_buffer_bank.sv ----
`timescale 1ns/10ps
`default_nettype none
module otpb_buffer_bank
    import otpb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hostWe,
    input  wire logic [1:0]  hostBuf,
    input  wire logic [3:0]  hostIdx,
    input  wire logic [15:0] hostWdata,
    input  wire logic [1:0]  rdBuf,
    input  wire logic [3:0]  rdIdx,
    output logic      [15:0] rdWord,
    input  wire logic        coreWe,
    input  wire logic [1:0]  coreBuf,
    input  wire logic [3:0]  coreIdx,
    input  wire logic [15:0] coreWdata
);
    // Three buffers of BUF_WORDS each; core port wins a same-word clash
    logic [15:0] mem [0:3*BUF_WORDS-1];

    function automatic logic [5:0] flat(input logic [1:0] b,
                                         input logic [3:0] i);
        flat = 6'(b) * 6'd16 + 6'(i);
    endfunction : flat

    wire [5:0] hostA = flat(hostBuf, hostIdx);
    wire [5:0] coreA = flat(coreBuf, coreIdx);
    wire [5:0] rdA   = flat(rdBuf, rdIdx);

    always_ff @(posedge clk) begin
        if (hostWe && !(coreWe && coreA == hostA)) begin
            mem[hostA] <= hostWdata;
        end
        if (coreWe) begin
            mem[coreA] <= coreWdata;
        end
    end

    assign rdWord = mem[rdA];
endmodule : otpb_buffer_bank
`default_nettype wire

// ---- rtl/otpb_device.sv ----
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module otpb_device
    import otpb_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    otpb_link_if.dev  link
);
    typedef enum logic [2:0] {
        DS_BOOT, DS_IDLE, DS_LOAD, DS_PROG, DS_LOCKCHK
    } otpb_dstate_t;

    otpb_dstate_t state_r, state_nxt;
    logic        otpMode_r;
    logic        locked_r;
    logic        error_r;
    logic [5:0]  blk_r;
    logic [5:0]  page_r;
    logic [3:0]  sector_r;
    logic [1:0]  bufSel_r;
    logic [1:0]  target_r;
    logic [7:0]  cnt_r;
    logic        toggle_r;
    logic        opFail_r;
    logic [63:0] otpWritten_r  = 64'h0000_0000_0000_0000;
    logic [15:0] otpLockWord_r = 16'hFFFF;
    logic        busyOut_r;
    logic        rdDone_r;
    logic [15:0] rdData_r;

    // Array contents are abstracted; core writes a page-derived pattern
    wire        busy     = state_r != DS_IDLE;
    wire        isCmd    = link.cmdValid;
    wire [15:0] code     = link.cmdCode;
    wire        isLoad   = isCmd && (code == CMD_LOAD ||
                           code == CMD_LOAD_SPARE || code == CMD_LOAD_ALT);
    wire        isProg   = isCmd && code == CMD_PROGRAM;
    wire        isErase  = isCmd && code == CMD_ERASE;
    wire        isReset  = isCmd && (code == CMD_CORE_RESET ||
                                     code == CMD_HOT_RESET);
    wire        addrHit  = link.addrValid && link.addrSel != AR_BUFSEL;
    wire        inLoad   = state_r == DS_LOAD || state_r == DS_BOOT;
    wire        lastCyc  = cnt_r == 8'd0;
    wire        pageUser = page_r <= OTP_USER_LAST;
    wire        progOk   = !(otpMode_r &&
                           (locked_r || otpWritten_r[page_r] || !pageUser));
    wire        coreWe   = inLoad && cnt_r < 8'(BUF_WORDS);
    wire [3:0]  coreIdx  = cnt_r[3:0];
    wire [15:0] coreData = {otpMode_r, 3'h0, blk_r[5:0], page_r};
    wire        tgtRead  = inLoad && link.rdValid && bufSel_r == target_r;
    wire [15:0] bankWord;
    wire        hostWe   = link.wrValid &&
                           !(state_r == DS_PROG && bufSel_r == target_r);

    otpb_buffer_bank u_bank (
        .clk       (clk),
        .rst_n     (rst_n),
        .hostWe    (hostWe),
        .hostBuf   (bufSel_r),
        .hostIdx   (link.wrIdx),
        .hostWdata (link.wrData),
        .rdBuf     (bufSel_r),
        .rdIdx     (link.rdIdx),
        .rdWord    (bankWord),
        .coreWe    (coreWe),
        .coreBuf   (target_r),
        .coreIdx   (coreIdx),
        .coreWdata (coreData)
    );

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            DS_BOOT:    if (lastCyc) state_nxt = DS_LOCKCHK;
            DS_LOCKCHK: state_nxt = DS_IDLE;
            DS_IDLE: begin
                if (isLoad) begin
                    state_nxt = DS_LOAD;
                end else if (isProg && progOk) begin
                    state_nxt = DS_PROG;
                end
            end
            DS_LOAD:    if (lastCyc || isReset) state_nxt = DS_IDLE;
            DS_PROG:    if (lastCyc || isReset) state_nxt = DS_IDLE;
            default:    state_nxt = DS_IDLE;
        endcase
    end

    // Cold and warm link resets both leave OTP access mode; only a cold reset restarts the boot sequence, and neither clears locked_r or error_r
    wire hardRst = link.coldRst || link.warmRst;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= DS_BOOT;
            cnt_r     <= 8'(BOOT_CYC);
            busyOut_r <= 1'b1;
        end else if (link.coldRst) begin
            state_r   <= DS_BOOT;
            cnt_r     <= 8'(BOOT_CYC);
            busyOut_r <= 1'b1;
        end else begin
            state_r   <= state_nxt;
            busyOut_r <= state_nxt != DS_IDLE;
            if (state_r == DS_IDLE && isLoad) begin
                cnt_r <= 8'(LOAD_CYC);
            end else if (state_r == DS_IDLE && isProg) begin
                cnt_r <= 8'(PROG_CYC);
            end else if (!lastCyc) begin
                cnt_r <= cnt_r - 8'd1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            otpMode_r <= 1'b0;
        end else if (hardRst || isReset) begin
            otpMode_r <= 1'b0;
        end else if (isCmd && code == CMD_OTP_ACCESS && !busy) begin
            otpMode_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blk_r    <= 6'h00;
            page_r   <= 6'h00;
            sector_r <= 4'h0;
            bufSel_r <= BUF_BOOT;
        end else if (link.addrValid) begin
            case (link.addrSel)
                AR_BLOCK:  blk_r    <= link.addrData[5:0];
                AR_PAGE:   page_r   <= link.addrData[5:0];
                AR_SECTOR: sector_r <= link.addrData[3:0];
                default:   bufSel_r <= link.addrData[1:0];
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            target_r <= BUF_BOOT;
            opFail_r <= 1'b0;
        end else if (state_r == DS_IDLE && (isLoad || isProg)) begin
            target_r <= bufSel_r;
            opFail_r <= 1'b0;
        end else if ((state_r == DS_LOAD || state_r == DS_PROG) &&
                     addrHit) begin
            opFail_r <= 1'b1;
        end
    end

    // Lock word and programmed-page map live in the array and survive reset;
    // a fresh part starts erased
    always_ff @(posedge clk) begin
        if (state_r == DS_PROG && lastCyc && !opFail_r && otpMode_r) begin
            otpWritten_r[page_r] <= 1'b1;
            if (page_r == 6'h00) begin
                otpLockWord_r <= bankWord;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            locked_r <= 1'b0;
            error_r  <= 1'b0;
        end else begin
            if (state_r == DS_LOCKCHK &&
                otpLockWord_r[3:0] == LOCK_NIBBLE) begin
                locked_r <= 1'b1;
            end
            if (state_r == DS_IDLE && isProg) begin
                error_r <= !progOk;
            end else if (state_r == DS_IDLE && isErase) begin
                error_r <= otpMode_r;
            end else if ((state_r == DS_LOAD || state_r == DS_PROG) &&
                         lastCyc) begin
                error_r <= opFail_r || addrHit;
            end
        end
    end

    // Toggle after the settle time of a load, from the command's countdown; during boot at once
    wire toggleLive = state_r == DS_BOOT ||
                      cnt_r <= 8'(LOAD_CYC - TOGGLE_CYC);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            toggle_r <= 1'b0;
            rdDone_r <= 1'b0;
            rdData_r <= 16'h0000;
        end else begin
            rdDone_r <= link.rdValid;
            if (tgtRead && toggleLive) begin
                toggle_r <= ~toggle_r;
                rdData_r <= {9'h000, ~toggle_r, 6'h00};
            end else begin
                rdData_r <= bankWord;
            end
        end
    end

    assign link.rdDone     = rdDone_r;
    assign link.rdData     = rdData_r;
    assign link.ctrlStatus = {busyOut_r, 4'h0, error_r, 3'h0, locked_r,
                              5'h00, otpMode_r};
endmodule : otpb_device
`default_nettype wire

// ---- rtl/otpb_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module otpb_host
    import otpb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    otpb_link_if.hst         link
);
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [15:0] cmd_r;
    logic [19:0] addr_r;
    logic [15:0] wdata_r;
    logic [15:0] rdata_r;
    logic [3:0]  op_r;
    logic        cmdV_r, addrV_r, wrV_r, rdV_r, coldR_r, warmR_r;

    // Writing RG_OP launches one link pulse (two if bit 2 is set with a kind other than OP_CMD); software must not change
    // address registers while the device reports busy (bit 15)
    // Writes commit at the access edge, when pready is sampled high
    wire setup  = psel && !penable;
    wire access = psel && penable && pready_r;
    wire wr     = access && pwrite;
    wire goOp   = wr && paddr == RG_OP;
    wire mapped = paddr == RG_CMD || paddr == RG_ADDR ||
                  paddr == RG_WDATA || paddr == RG_RDATA ||
                  paddr == RG_STATUS || paddr == RG_OP;
    wire [31:0] rdMux =
        paddr == RG_CMD    ? {16'h0000, cmd_r} :
        paddr == RG_ADDR   ? {12'h000, addr_r} :
        paddr == RG_WDATA  ? {16'h0000, wdata_r} :
        paddr == RG_RDATA  ? {16'h0000, rdata_r} :
        paddr == RG_STATUS ? {16'h0000, link.ctrlStatus} :
        paddr == RG_OP     ? {28'h000_0000, op_r} : APB_ERRV;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            cmd_r     <= 16'h0000;
            addr_r    <= 20'h0_0000;
            wdata_r   <= 16'h0000;
            op_r      <= 4'h0;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup && !mapped;
            if (setup && !pwrite) prdata_r <= rdMux;
            if (wr && paddr == RG_CMD)   cmd_r   <= pwdata[15:0];
            if (wr && paddr == RG_ADDR)  addr_r  <= pwdata[19:0];
            if (wr && paddr == RG_WDATA) wdata_r <= pwdata[15:0];
            if (goOp)                    op_r    <= pwdata[3:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdV_r  <= 1'b0;
            addrV_r <= 1'b0;
            wrV_r   <= 1'b0;
            rdV_r   <= 1'b0;
            coldR_r <= 1'b0;
            warmR_r <= 1'b0;
            rdata_r <= 16'h0000;
        end else begin
            // are software sequences using these pulses
            cmdV_r  <= goOp && pwdata[1:0] == OP_CMD && !pwdata[2];
            addrV_r <= goOp && pwdata[1:0] == OP_ADDR;
            wrV_r   <= goOp && pwdata[1:0] == OP_WRITE;
            rdV_r   <= goOp && pwdata[1:0] == OP_READ;
            coldR_r <= goOp && pwdata[2] && !pwdata[3];
            warmR_r <= goOp && pwdata[2] && pwdata[3];
            if (link.rdDone) rdata_r <= link.rdData;
        end
    end

    assign prdata         = prdata_r;
    assign pready         = pready_r;
    assign pslverr        = pslverr_r;
    assign link.cmdValid  = cmdV_r;
    assign link.cmdCode   = cmd_r;
    assign link.addrValid = addrV_r;
    assign link.addrSel   = addr_r[17:16];
    assign link.addrData  = addr_r[15:0];
    assign link.wrValid   = wrV_r;
    assign link.wrIdx     = addr_r[3:0];
    assign link.wrData    = wdata_r;
    assign link.rdValid   = rdV_r;
    assign link.rdIdx     = addr_r[3:0];
    assign link.coldRst   = coldR_r;
    assign link.warmRst   = warmR_r;
endmodule : otpb_host
`default_nettype wire

// ---- dv/otpb_link_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module otpb_link_properties
    import otpb_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        cmdValid,
    input wire logic [15:0] cmdCode,
    input wire logic        addrValid,
    input wire logic [1:0]  addrSel,
    input wire logic        rdValid,
    input wire logic        rdDone,
    input wire logic [15:0] ctrlStatus,
    input wire logic        coldRst,
    input wire logic        warmRst
);
    // ----------------------------------------------------------------
    // Helper logic and properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic       busy;
    logic       mode;
    logic       clrReq;
    logic       cmdIdle;
    logic [2:0] clrHist_r;
    logic       addrHit_r;

    assign busy    = ctrlStatus[ST_BUSY];
    assign mode    = ctrlStatus[ST_OTPMOD];
    assign cmdIdle = cmdValid && !busy;
    assign clrReq  = warmRst || coldRst || (cmdValid &&
        (cmdCode == CMD_CORE_RESET || cmdCode == CMD_HOT_RESET));

    // Clears may land a cycle or two late, so remember recent requests
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clrHist_r <= 3'h0;
            addrHit_r <= 1'b0;
        end else begin
            clrHist_r <= {clrHist_r[1:0], clrReq};
            addrHit_r <= busy && (addrHit_r ||
                                  (addrValid && addrSel != AR_BUFSEL));
        end
    end

    property p_rd_answer;
        rdValid |=> rdDone;
    endproperty
    property p_rd_quiet;
        !rdValid |=> !rdDone;
    endproperty
    property p_otp_enter;
        cmdIdle && cmdCode == CMD_OTP_ACCESS |-> ##[1:3] mode;
    endproperty
    property p_otp_leave;
        $fell(mode) |-> (clrHist_r != 3'h0);
    endproperty
    property p_warm_exit;
        warmRst |-> ##[1:3] !mode;
    endproperty
    property p_erase_refused;
        cmdIdle && cmdCode == CMD_ERASE && mode
            |-> ##[1:3] ctrlStatus[ST_ERROR];
    endproperty
    property p_locked_refused;
        cmdIdle && cmdCode == CMD_PROGRAM && mode && ctrlStatus[ST_LOCKED]
            |-> ##[1:3] (ctrlStatus[ST_ERROR] && !busy);
    endproperty
    property p_lock_held;
        ctrlStatus[ST_LOCKED] && !busy |=> ctrlStatus[ST_LOCKED] || busy;
    endproperty
    property p_addr_fails;
        $fell(busy) && addrHit_r |-> ##[0:2] ctrlStatus[ST_ERROR];
    endproperty
    property p_load_starts;
        cmdIdle && cmdCode == CMD_LOAD |-> ##[1:2] busy[*2];
    endproperty

    a_rd_answer:      assert property (p_rd_answer)
        else $error("read answer missing");
    a_rd_quiet:       assert property (p_rd_quiet)
        else $error("read answer without request");
    a_otp_enter:      assert property (p_otp_enter)
        else $error("access mode not entered");
    a_otp_leave:      assert property (p_otp_leave)
        else $error("access mode left without reset");
    a_warm_exit:      assert property (p_warm_exit)
        else $error("access mode kept after warm reset");
    a_erase_refused:  assert property (p_erase_refused)
        else $error("erase of otp block not refused");
    a_locked_refused: assert property (p_locked_refused)
        else $error("program of locked block not refused");
    a_lock_held:      assert property (p_lock_held)
        else $error("lock flag dropped");
    a_addr_fails:     assert property (p_addr_fails)
        else $error("address change did not fail operation");
    a_load_starts:    assert property (p_load_starts)
        else $error("load did not start");

    c_load:  cover property (cmdIdle && cmdCode == CMD_LOAD);
    c_lock:  cover property ($rose(ctrlStatus[ST_LOCKED]));
    c_erase: cover property (cmdIdle && cmdCode == CMD_ERASE && mode);
endmodule : otpb_link_properties
`default_nettype wire

// ---- dv/tb_otp_dual_buffer_control.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_otp_dual_buffer_control
    import otpb_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] rd;
    logic        lastErr;
    int          mismatches = 0;
    int          comparisons = 0;

    always #5 clk = ~clk;

    otpb_link_if lnk ();
    otpb_device otpb_device_i (.clk(clk), .rst_n(rst_n), .link(lnk));
    otpb_host otpb_host_i (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk));
    otpb_link_properties otpb_link_properties_i (.clk(clk), .rst_n(rst_n),
        .cmdValid(lnk.cmdValid), .cmdCode(lnk.cmdCode),
        .addrValid(lnk.addrValid), .addrSel(lnk.addrSel),
        .rdValid(lnk.rdValid), .rdDone(lnk.rdDone),
        .ctrlStatus(lnk.ctrlStatus), .coldRst(lnk.coldRst),
        .warmRst(lnk.warmRst));

    // ----------------------------------------------------------------
    // Bus and comparison tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One idle cycle after each transfer keeps psel single-driven per step
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) mismatches++;
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic op_cmd(input logic [15:0] c);
        apb(1'b1, RG_CMD, {16'h0000, c});
        apb(1'b1, RG_OP, {30'h0, OP_CMD});
        repeat (2) @(posedge clk);
    endtask : op_cmd

    task automatic op_addr(input logic [1:0] s, input logic [15:0] d);
        apb(1'b1, RG_ADDR, {14'h0, s, d});
        apb(1'b1, RG_OP, {30'h0, OP_ADDR});
    endtask : op_addr

    task automatic op_wr(input logic [3:0] i, input logic [15:0] d);
        apb(1'b1, RG_ADDR, {28'h0, i});
        apb(1'b1, RG_WDATA, {16'h0000, d});
        apb(1'b1, RG_OP, {30'h0, OP_WRITE});
    endtask : op_wr

    task automatic op_rd(input logic [3:0] i);
        apb(1'b1, RG_ADDR, {28'h0, i});
        apb(1'b1, RG_OP, {30'h0, OP_READ});
        repeat (4) @(posedge clk);
        apb(1'b0, RG_RDATA, 32'h0000_0000);
    endtask : op_rd

    task automatic wait_idle();
        repeat (3) @(posedge clk);
        for (int n = 0; n < 200; n++) begin
            apb(1'b0, RG_STATUS, 32'h0000_0000);
            if (rd[ST_BUSY] === 1'b0) break;
        end
        if (rd[ST_BUSY] !== 1'b0) mismatches++;
    endtask : wait_idle

    task automatic end_of_test();
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_boot();
        wait_idle();
        chk(rd[ST_OTPMOD], 1'b0);
        chk(rd[ST_LOCKED], 1'b0);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk(rd, APB_ERRV);
        chk(lastErr, 1'b1);
    endtask : t_boot

    // Every exit path: warm, core, hot and cold reset
    task automatic t_mode();
        logic [31:0] v;
        for (int i = 0; i < 4; i++) begin
            op_cmd(CMD_OTP_ACCESS);
            apb(1'b0, RG_STATUS, 32'h0000_0000);
            chk(rd[ST_OTPMOD], 1'b1);
            op_cmd(CMD_ERASE);
            apb(1'b0, RG_STATUS, 32'h0000_0000);
            chk(rd[ST_ERROR], 1'b1);
            chk(rd[ST_OTPMOD], 1'b1);
            case (i)
                0: apb(1'b1, RG_OP, 32'h0000_000C);
                1: op_cmd(CMD_CORE_RESET);
                2: op_cmd(CMD_HOT_RESET);
                default: begin
                    apb(1'b1, RG_OP, 32'h0000_0004);
                    op_addr(AR_BUFSEL, {14'h0, BUF_BOOT});
                    op_rd(4'h0);
                    v = rd;
                    op_rd(4'h0);
                    chk(rd[6], !v[6]);
                end
            endcase
            wait_idle();
            chk(rd[ST_OTPMOD], 1'b0);
        end
    endtask : t_mode

    task automatic t_dual();
        logic [31:0] v;
        op_addr(AR_BUFSEL, {14'h0, BUF_DATA1});
        op_wr(4'h3, 16'h1234);
        op_addr(AR_BUFSEL, {14'h0, BUF_DATA0});
        op_cmd(CMD_LOAD);
        op_addr(AR_BUFSEL, {14'h0, BUF_DATA1});
        op_rd(4'h3);
        chk(rd[15:0], 16'h1234);
        op_addr(AR_BUFSEL, {14'h0, BUF_DATA0});
        repeat (8) @(posedge clk);
        op_rd(4'h0);
        v = rd;
        op_rd(4'h0);
        chk(rd[6], !v[6]);
        wait_idle();
        chk(rd[ST_ERROR], 1'b0);
        op_rd(4'h0);
        v = rd;
        op_rd(4'h0);
        chk(rd, v);
    endtask : t_dual

    task automatic t_fail();
        op_cmd(CMD_LOAD);
        op_addr(AR_PAGE, 16'h0001);
        wait_idle();
        chk(rd[ST_ERROR], 1'b1);
        op_cmd(CMD_PROGRAM);
        op_addr(AR_SECTOR, 16'h0000);
        wait_idle();
        chk(rd[ST_ERROR], 1'b1);
        op_wr(4'h5, 16'h1111);
        op_cmd(CMD_PROGRAM);
        op_wr(4'h5, 16'h2222);
        op_addr(AR_BUFSEL, {14'h0, BUF_DATA1});
        op_wr(4'h5, 16'h3333);
        wait_idle();
        chk(rd[ST_ERROR], 1'b0);
        op_rd(4'h5);
        chk(rd[15:0], 16'h3333);
        op_addr(AR_BUFSEL, {14'h0, BUF_DATA0});
        op_rd(4'h5);
        chk(rd[15:0], 16'h1111);
    endtask : t_fail

    task automatic t_lock();
        op_cmd(CMD_OTP_ACCESS);
        op_addr(AR_PAGE, 16'h000A);
        op_cmd(CMD_PROGRAM);
        wait_idle();
        chk(rd[ST_ERROR], 1'b1);
        op_wr(LOCK_WORD_IDX, 16'h005C);
        op_addr(AR_PAGE, 16'h0000);
        op_addr(AR_BLOCK, 16'h0005);
        apb(1'b1, RG_ADDR, {28'h0, LOCK_WORD_IDX});
        op_cmd(CMD_PROGRAM);
        wait_idle();
        chk(rd[ST_ERROR], 1'b0);
        op_cmd(CMD_PROGRAM);
        wait_idle();
        chk(rd[ST_ERROR], 1'b1);
        apb(1'b1, RG_OP, 32'h0000_0004);
        wait_idle();
        chk(rd[ST_LOCKED], 1'b1);
        chk(rd[ST_OTPMOD], 1'b0);
        op_cmd(CMD_OTP_ACCESS);
        op_cmd(CMD_PROGRAM);
        wait_idle();
        chk(rd[ST_ERROR], 1'b1);
        chk(rd[ST_LOCKED], 1'b1);
    endtask : t_lock

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_boot();
        t_mode();
        t_dual();
        t_fail();
        t_lock();
        end_of_test();
    end

    // Whole run needs about a thousand cycles; this is some thirty times that
    initial begin
        #300000;
        mismatches++;
        end_of_test();
    end
endmodule : tb_otp_dual_buffer_control
`default_nettype wire
